// ==== hdl/pei_top.sv ====
// Notes on behaviour
// [R1] Toggle with no address enters at zero.
// [R2] Toggle in immediate mode starts entry at its address.
// [R3] Toggle during entry returns to immediate mode.
// [R4] Escape also ends entry.
// [R5] Each finished line is stored in program memory.
// [R6] Single-axis entry prints the address first; multi-axis not.
// [R7] Host prefixes multi-axis lines with the axis name.
// [R8] Multi-axis entry echoes only name and letter.
// [R9] Backspace clears the line; single-axis reprints the address.
// [R10] Multi-axis backspace keeps the name, shows no address.
// [R11] Invalid letter refused; single-axis repeats the address.
// [R12] Multi-axis: invalid letter ignored, following valid one taken.
// [R13] Multi-axis invalid line dropped; next line needs the name.
// [R14] Map: program 0-191, vectors 192-199, reserved 200-255, program 256-1023.
// [R15] Entry above 1023 or within 200-255 is discarded.
// [R16] Execute with address starts the program there.
// [R17] Reset copies the non-volatile image into memory.
// [R18] Settings command without data replies with the value.
// [R19] Settings value is polarity plus step/direction enable.
// [R20] Polarity picks closed or open home and limit switches.
// [R21] Step/direction enable drives outputs 1 and 2.
// [R22] Entry address advances by the command's size.
//
// Added by the designer: register access over APB and the register offsets.
`default_nettype none

module pei_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [pei_pkg::MEM_AW-1:0] nv_addr,
    input wire logic [pei_pkg::WORD_W-1:0] nv_data,
    output logic exec_start,
    output logic [pei_pkg::ADDR_W-1:0] exec_addr,
    input wire logic home_raw,
    input wire logic [1:0] limit_raw,
    input wire logic [1:0] gp_req,
    input wire logic step_pulse,
    input wire logic step_dir,
    output logic home_active,
    output logic [1:0] limit_active,
    output logic [1:0] gp_out
);
    import pei_pkg::*;

    ////////////////////////////////////////
    // Submodules

    pei_mem_if mem_if ();
    pei_set_if set_if ();

    pei_prog_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .m(mem_if.mem)
    );

    pei_settings u_set (
        .pclk(pclk),
        .presetn(presetn),
        .s(set_if.set),
        .home_raw(home_raw),
        .limit_raw(limit_raw),
        .gp_req(gp_req),
        .step_pulse(step_pulse),
        .step_dir(step_dir),
        .home_active(home_active),
        .limit_active(limit_active),
        .gp_out(gp_out)
    );

    ////////////////////////////////////////
    // State

    pei_state_e state_ff;
    pei_state_e nxt_state;
    logic prog_ff;
    logic nxt_prog;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd;
    logic [15:0] data_ff;
    logic [15:0] nxt_data;
    logic has_data_ff;
    logic nxt_has_data;
    logic multi_ff;
    logic [7:0] name_ff;
    logic [MEM_AW-1:0] load_idx_ff;
    logic [MEM_AW-1:0] mem_idx_ff;
    logic [31:0] prdata_ff;
    logic [7:0] msg_ff [MSG_MAX];
    logic [3:0] msg_len_ff;
    logic [3:0] msg_pos_ff;
    logic exec_start_ff;
    logic [ADDR_W-1:0] exec_addr_ff;
    pei_msg_e msg_kind;
    logic store;
    logic parse_set_wr;
    logic exec_go;
    logic [7:0] msg_buf [MSG_MAX];
    logic [3:0] msg_len;

    ////////////////////////////////////////
    // Character decode

    wire loading = (state_ff == PEI_LOAD);
    wire tx_idle = (msg_pos_ff == msg_len_ff);
    wire rx_take = rx_valid && rx_ready;
    wire [7:0] c = rx_data;
    wire is_digit = (c >= CH_0) && (c <= CH_9);
    wire is_cr = (c == CH_CR);
    wire is_esc = (c == CH_ESC);
    wire is_bs = (c == CH_BS);
    wire is_blank = (c == CH_SP) || (c == CH_PLUS) || (c == CH_MINUS);
    wire is_upper = (c >= CH_UA) && (c <= CH_UZ);
    wire is_prog_cmd = is_upper || (c == CH_PLUS) || (c == CH_MINUS) || (c == CH_AT)
        || (c == CH_LP);
    wire single_prog = prog_ff && !multi_ff;
    wire pei_state_e line_start = multi_ff ? PEI_NAME : PEI_CMD;
    wire in_reserved = (addr_ff >= RSV_FIRST) && (addr_ff <= RSV_LAST); // [R14]
    wire addr_ok = (addr_ff <= MEM_LAST) && !in_reserved; // [R15]
    wire is_long = (cmd_ff == CH_O) || (cmd_ff == CH_R) || (cmd_ff == CH_PLUS)
        || (cmd_ff == CH_MINUS);
    wire [15:0] cmd_size = (cmd_ff == CH_M) ? SIZE_MOVE : (is_long ? SIZE_LONG : SIZE_SHORT);
    wire [15:0] digit_sum = 16'(data_ff * 16'h000A) + {12'h000, c[3:0]};

    ////////////////////////////////////////
    // Line parser

    always_comb begin
        nxt_state = state_ff;
        nxt_prog = prog_ff;
        nxt_addr = addr_ff;
        nxt_cmd = cmd_ff;
        nxt_data = data_ff;
        nxt_has_data = has_data_ff;
        msg_kind = MSG_NONE;
        store = 1'b0;
        parse_set_wr = 1'b0;
        exec_go = 1'b0;
        case (state_ff)
            PEI_LOAD: begin
                if (load_idx_ff == LOAD_LAST) begin
                    nxt_state = line_start;
                end
            end
            PEI_NAME: begin
                if (rx_take && (c == name_ff)) begin
                    nxt_state = PEI_CMD;
                    msg_kind = MSG_ECHO; // [R8]
                end
            end
            PEI_CMD: begin
                if (!rx_take) begin
                    nxt_state = state_ff;
                end else if (is_esc) begin
                    nxt_prog = 1'b0; // [R4]
                    nxt_state = line_start;
                    msg_kind = MSG_PROMPT;
                end else if (is_bs) begin
                    // Name stays accepted in multi-axis mode
                    msg_kind = multi_ff ? MSG_NONE : MSG_PROMPT; // [R9] [R10]
                end else if (is_cr) begin
                    nxt_state = line_start; // [R13]
                    msg_kind = multi_ff ? MSG_NONE : MSG_PROMPT;
                end else if (is_prog_cmd) begin
                    nxt_cmd = c; // [R12]
                    nxt_data = 16'h0000;
                    nxt_has_data = 1'b0;
                    nxt_state = PEI_DATA;
                    msg_kind = MSG_ECHO; // [R8]
                end else if (single_prog && (c != CH_SP)) begin
                    msg_kind = MSG_PROMPT; // [R11]
                end
            end
            PEI_DATA: begin
                if (!rx_take) begin
                    nxt_state = state_ff;
                end else if (is_digit) begin
                    nxt_data = digit_sum;
                    nxt_has_data = 1'b1;
                    msg_kind = multi_ff ? MSG_NONE : MSG_ECHO; // [R8]
                end else if (is_esc) begin
                    nxt_prog = 1'b0; // [R4]
                    nxt_state = line_start;
                    msg_kind = MSG_PROMPT;
                end else if (is_bs) begin
                    nxt_state = PEI_CMD; // [R9] [R10]
                    msg_kind = multi_ff ? MSG_NONE : MSG_PROMPT; // [R9]
                end else if (is_cr) begin
                    nxt_state = line_start;
                    msg_kind = MSG_PROMPT;
                    if (prog_ff) begin
                        if (cmd_ff == CH_P) begin
                            nxt_prog = 1'b0; // [R3]
                        end else begin
                            store = addr_ok; // [R5] [R15]
                            nxt_addr = 16'(addr_ff + cmd_size); // [R22]
                        end
                    end else begin
                        case (cmd_ff)
                            CH_P: begin
                                nxt_prog = 1'b1; // [R2]
                                nxt_addr = has_data_ff ? data_ff : 16'h0000; // [R1]
                            end
                            CH_LP: begin
                                if (has_data_ff) begin
                                    parse_set_wr = (data_ff <= SET_MAX); // [R19]
                                    msg_kind = MSG_PROMPT;
                                end else begin
                                    msg_kind = MSG_SET; // [R18]
                                end
                            end
                            CH_G: begin
                                exec_go = 1'b1; // [R16]
                            end
                            default: begin
                                msg_kind = MSG_PROMPT;
                            end
                        endcase
                    end
                end else if (is_blank && !multi_ff) begin
                    msg_kind = MSG_ECHO;
                end
            end
            default: begin
                nxt_state = PEI_LOAD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= PEI_LOAD;
            prog_ff <= 1'b0;
            addr_ff <= '0;
            cmd_ff <= 8'h00;
            data_ff <= 16'h0000;
            has_data_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            prog_ff <= nxt_prog;
            addr_ff <= nxt_addr;
            cmd_ff <= nxt_cmd;
            data_ff <= nxt_data;
            has_data_ff <= nxt_has_data;
        end
    end

    ////////////////////////////////////////
    // Image copy after reset and memory port

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_idx_ff <= '0;
        end else if (loading && (load_idx_ff != LOAD_LAST)) begin
            load_idx_ff <= load_idx_ff + 10'h001; // [R17]
        end
    end

    assign nv_addr = load_idx_ff;
    assign mem_if.wr_en = loading || store; // [R17] [R5]
    assign mem_if.wr_addr = loading ? load_idx_ff : addr_ff[MEM_AW-1:0];
    assign mem_if.wr_data = loading ? nv_data : {cmd_ff, data_ff};
    assign mem_if.rd_addr = mem_idx_ff;

    ////////////////////////////////////////
    // Execute request

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_start_ff <= 1'b0;
            exec_addr_ff <= '0;
        end else begin
            exec_start_ff <= exec_go; // [R16]
            if (exec_go) begin
                exec_addr_ff <= has_data_ff ? data_ff : 16'h0000;
            end
        end
    end

    assign exec_start = exec_start_ff;
    assign exec_addr = exec_addr_ff;

    ////////////////////////////////////////
    // Console replies

    wire [15:0] pa = nxt_addr % 16'h2710;
    wire [3:0] dig [4];
    assign dig[0] = 4'(pa / 16'h03E8);
    assign dig[1] = 4'((pa / 16'h0064) % 16'h000A);
    assign dig[2] = 4'((pa / 16'h000A) % 16'h000A);
    assign dig[3] = 4'(pa % 16'h000A);
    wire show_addr = nxt_prog && !multi_ff; // [R6]

    always_comb begin
        for (int i = 0; i < MSG_MAX; i++) begin
            msg_buf[i] = CH_SP;
        end
        msg_len = 4'h0;
        case (msg_kind)
            MSG_ECHO: begin
                msg_buf[0] = c;
                msg_len = 4'h1;
            end
            MSG_PROMPT: begin
                msg_buf[0] = CH_CR;
                msg_buf[1] = CH_LF;
                msg_len = 4'h2;
                if (show_addr) begin
                    for (int i = 0; i < 4; i++) begin
                        msg_buf[i + 2] = CH_0 + {4'h0, dig[i]}; // [R6] [R9] [R11]
                    end
                    msg_len = 4'h7;
                end
            end
            MSG_SET: begin
                msg_buf[0] = CH_LP;
                msg_buf[1] = CH_0 + {5'h00, set_if.value}; // [R18]
                msg_buf[2] = CH_CR;
                msg_buf[3] = CH_LF;
                msg_len = 4'h4;
            end
            default: begin
                msg_len = 4'h0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_len_ff <= 4'h0;
            msg_pos_ff <= 4'h0;
        end else if (rx_take) begin
            msg_len_ff <= msg_len;
            msg_pos_ff <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            msg_pos_ff <= msg_pos_ff + 4'h1;
        end
    end

    for (genvar i = 0; i < MSG_MAX; i++) begin : g_msg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                msg_ff[i] <= 8'h00;
            end else if (rx_take) begin
                msg_ff[i] <= msg_buf[i];
            end
        end
    end

    // Input stalls while a reply drains, so no character is lost
    assign rx_ready = !loading && tx_idle;
    assign tx_valid = !tx_idle;
    assign tx_data = msg_ff[msg_pos_ff[2:0]];

    ////////////////////////////////////////
    // APB slave

    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_set = (paddr == REG_SETTINGS);
    wire hit_idx = (paddr == REG_MEM_IDX);
    wire hit_data = (paddr == REG_MEM_DATA);
    wire hit_any = hit_ctrl || hit_status || hit_set || hit_idx || hit_data;
    wire apb_set_wr = apb_wr && hit_set;

    wire [31:0] rd_ctrl = {16'h0000, name_ff, 7'h00, multi_ff};
    wire [31:0] rd_status = {addr_ff, 14'h0000, loading, prog_ff};
    wire [31:0] rd_set = {29'h00000000, set_if.value};
    wire [31:0] rd_idx = {22'h000000, mem_idx_ff};
    wire [31:0] rd_data = {8'h00, mem_if.rd_data};
    wire [31:0] rd_val = hit_ctrl ? rd_ctrl : hit_status ? rd_status : hit_set ? rd_set
        : hit_idx ? rd_idx : hit_data ? rd_data : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multi_ff <= CTRL_MULTI_RST;
            name_ff <= CTRL_NAME_RST;
        end else if (apb_wr && hit_ctrl) begin
            multi_ff <= pwdata[CTRL_MULTI_BIT];
            name_ff <= pwdata[CTRL_NAME_LSB +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_idx_ff <= '0;
        end else if (apb_wr && hit_idx) begin
            mem_idx_ff <= pwdata[MEM_AW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (apb_setup) begin
            prdata_ff <= rd_val;
        end
    end

    // Bus write wins over a parser write in the same cycle
    assign set_if.wr_en = apb_set_wr || parse_set_wr; // [R19]
    assign set_if.wr_val = apb_set_wr ? pwdata[2:0] : data_ff[2:0];

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

endmodule

`default_nettype wire

// ==== hdl/pei_pkg.sv ====
`default_nettype none

package pei_pkg;

    ////////////////////////////////////////
    // Character codes
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ESC = 8'h1B;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UZ = 8'h5A;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_LP = 8'h70;

    ////////////////////////////////////////
    // Program memory and address map
    localparam int ADDR_W = 16;
    localparam int MEM_AW = 10;
    localparam int MEM_DEPTH = 1024;
    localparam int WORD_W = 24;
    localparam logic [15:0] PROG1_LAST = 16'h00BF;
    localparam logic [15:0] VEC_FIRST = 16'h00C0;
    localparam logic [15:0] VEC_LAST = 16'h00C7;
    localparam logic [15:0] RSV_FIRST = 16'h00C8;
    localparam logic [15:0] RSV_LAST = 16'h00FF;
    localparam logic [15:0] PROG2_FIRST = 16'h0100;
    localparam logic [15:0] MEM_LAST = 16'h03FF;
    localparam logic [9:0] LOAD_LAST = 10'h3FF;

    // Storage size of a command
    localparam logic [15:0] SIZE_SHORT = 16'h0002;
    localparam logic [15:0] SIZE_MOVE = 16'h0003;
    localparam logic [15:0] SIZE_LONG = 16'h0005;

    ////////////////////////////////////////
    // Registers
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SETTINGS = 8'h08;
    localparam logic [7:0] REG_MEM_IDX = 8'h0C;
    localparam logic [7:0] REG_MEM_DATA = 8'h10;
    localparam int CTRL_MULTI_BIT = 0;
    localparam int CTRL_NAME_LSB = 8;
    localparam int STAT_PROG_BIT = 0;
    localparam int STAT_LOAD_BIT = 1;
    localparam int STAT_ADDR_LSB = 16;
    localparam int SET_POL_LSB = 0;
    localparam int SET_STEP_BIT = 2;
    localparam logic CTRL_MULTI_RST = 1'h0;
    localparam logic [7:0] CTRL_NAME_RST = 8'h41;
    localparam logic [2:0] SET_RST = 3'h0;
    localparam logic [15:0] SET_MAX = 16'h0007;

    ////////////////////////////////////////
    // Line parser states and reply kinds
    typedef enum logic [1:0] {
        PEI_LOAD = 2'b00,
        PEI_NAME = 2'b01,
        PEI_CMD = 2'b11,
        PEI_DATA = 2'b10
    } pei_state_e;

    typedef enum logic [1:0] {
        MSG_NONE = 2'b00,
        MSG_ECHO = 2'b01,
        MSG_PROMPT = 2'b10,
        MSG_SET = 2'b11
    } pei_msg_e;

    localparam int MSG_MAX = 8;

endpackage

`default_nettype wire

// ==== hdl/pei_if.sv ====
`default_nettype none

interface pei_mem_if;
    logic wr_en;
    logic [pei_pkg::MEM_AW-1:0] wr_addr;
    logic [pei_pkg::WORD_W-1:0] wr_data;
    logic [pei_pkg::MEM_AW-1:0] rd_addr;
    logic [pei_pkg::WORD_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

interface pei_set_if;
    logic wr_en;
    logic [2:0] wr_val;
    logic [2:0] value;
    modport ctrl (output wr_en, output wr_val, input value);
    modport set (input wr_en, input wr_val, output value);
endinterface

`default_nettype wire

// ==== hdl/pei_prog_mem.sv ====
`default_nettype none

module pei_prog_mem (
    input wire logic pclk,
    input wire logic presetn,
    pei_mem_if.mem m
);
    import pei_pkg::*;

    logic [WORD_W-1:0] word_ff [MEM_DEPTH];

    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word_ff[i] <= '0;
            end else if (m.wr_en && (m.wr_addr == MEM_AW'(i))) begin
                word_ff[i] <= m.wr_data;
            end
        end
    end

    assign m.rd_data = word_ff[m.rd_addr];

endmodule

`default_nettype wire

// ==== hdl/pei_settings.sv ====
`default_nettype none

module pei_settings (
    input wire logic pclk,
    input wire logic presetn,
    pei_set_if.set s,
    input wire logic home_raw,
    input wire logic [1:0] limit_raw,
    input wire logic [1:0] gp_req,
    input wire logic step_pulse,
    input wire logic step_dir,
    output logic home_active,
    output logic [1:0] limit_active,
    output logic [1:0] gp_out
);
    import pei_pkg::*;

    logic [2:0] value_ff;
    logic home_ff;
    logic [1:0] limit_ff;
    logic [1:0] gp_ff;
    wire [1:0] switch_polarity_field = value_ff[SET_POL_LSB +: 2];
    wire step_dir_output_field = value_ff[SET_STEP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= SET_RST;
        end else if (s.wr_en) begin
            value_ff <= s.wr_val; // [R19]
        end
    end

    // Raw high means the contact is closed; a closed-type switch is active when open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_ff <= 1'b0;
            limit_ff <= 2'h0;
            gp_ff <= 2'h0;
        end else begin
            home_ff <= home_raw ^ switch_polarity_field[1]; // [R20]
            limit_ff <= limit_raw ^ {2{switch_polarity_field[0]}}; // [R20]
            gp_ff <= step_dir_output_field ? {step_dir, step_pulse} : gp_req; // [R21]
        end
    end

    assign s.value = value_ff;
    assign home_active = home_ff;
    assign limit_active = limit_ff;
    assign gp_out = gp_ff;

endmodule

`default_nettype wire

// ==== tb/pei_top_sva.sv ====
`default_nettype none
module pei_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic exec_start,
    input wire logic home_raw,
    input wire logic home_active
);
    import pei_pkg::*;
    wire logic quiet = presetn && !psel && !rx_valid;
    wire logic acc = psel && penable;
    wire logic tx_go = tx_valid && tx_ready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_apb_ready: assert property (acc |-> pready) else $error("pready low");
    chk_apb_unmapped: assert property (acc && paddr > REG_MEM_DATA |-> pslverr)
        else $error("no err");
    chk_apb_mapped: assert property (acc && paddr == REG_SETTINGS |-> !pslverr)
        else $error("bad err");
    chk_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx lost");
    chk_rx_blocked: assert property (tx_valid |-> !rx_ready) else $error("rx open");
    chk_exec_pulse: assert property (exec_start |=> !exec_start) else $error("exec long");
    chk_prompt_crlf: assert property (tx_go && tx_data == CH_CR |=> tx_data == CH_LF)
        else $error("no lf");
    chk_home_track: assert property (quiet && $past(quiet) && $changed(home_raw)
        |=> $changed(home_active)) else $error("home stuck");
    cover property (exec_start);
    cover property (acc && pslverr);
    cover property (tx_go && tx_data == CH_LF);
endmodule
bind pei_top pei_top_sva pei_top_sva_inst (.*);
`default_nettype wire

// ==== tb/pei_host.sv ====
`default_nettype none
module pei_host (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import pei_pkg::*;
    int seed = 32'h6F8C;
    logic [31:0] r;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hFF;
        tx_ready = 1'b0;
    end
    // Console sink stalls at random
    always @(posedge pclk) begin
        r = $random(seed);
        tx_ready <= r[1:0] != 2'h0;
    end
    // Holds a character until taken, then scrambles the idle line
    task automatic put(input logic [7:0] c);
        rx_valid <= 1'b1;
        rx_data <= c;
        @(posedge pclk);
        while (rx_ready !== 1'b1) @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~c;
        @(posedge pclk);
    endtask
    task automatic line(input bit multi, input string s);
        if (multi) put(CH_UA);
        foreach (s[i]) put(s[i]);
        put(CH_CR);
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pei_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, rx_valid, rx_ready, tx_valid, tx_ready;
    logic exec_start, home_raw, home_active, step_pulse, step_dir, pready, pslverr;
    logic [1:0] limit_raw, limit_active, gp_req, gp_out;
    logic [7:0] paddr, rx_data, tx_data;
    logic [31:0] pwdata, prdata;
    logic [MEM_AW-1:0] nv_addr;
    logic [ADDR_W-1:0] exec_addr;
    logic [7:0] tx_q[$];
    logic [32:0] rd_q[$];
    logic [16:0] ex = '0;
    logic [2:0] v;
    int fails = 0, num_checks = 0, cyc = 0, seed = 32'h6F8C;
    wire logic [WORD_W-1:0] nv_data = {8'h4B, 6'h0, nv_addr};
    pei_top pei_top_inst (.*);
    pei_host pei_host_inst (.*);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        fails += tx_q.size();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (exec_start === 1'b1) ex <= {1'b1, exec_addr};
        if (tx_valid && tx_ready)
            check("tx_data", {25'h0, tx_q.size() > 0 ? tx_q.pop_front() : 8'hXX}, {25'h0, tx_data});
        if (psel && penable && pready && !pwrite)
            check("prdata", rd_q.pop_front(), {pslverr, prdata});
        if (cyc == 20000) begin
            fails++;
            finish_test;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic memrd(input logic [9:0] i, input logic [31:0] e);
        apb(1'b1, REG_MEM_IDX, {22'h0, i});
        rd(REG_MEM_DATA, {1'b0, e});
    endtask
    task automatic tx(input string s);
        @(posedge pclk);
        while (rx_ready !== 1'b1) @(posedge pclk);
        foreach (s[i]) tx_q.push_back(s[i]);
    endtask
    task automatic ln(input bit m, input string s);
        pei_host_inst.line(m, s);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {home_raw, limit_raw, gp_req, step_pulse, step_dir} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tx("");
        rd(REG_SETTINGS, {30'h0, SET_RST});
        rd(REG_CTRL, {17'h0, CTRL_NAME_RST, 7'h0, CTRL_MULTI_RST});
        rd(8'h20, 33'h1_0000_0000);
        memrd(10'h3E8, 32'h004B_03E8);
        v = 3'($random(seed));
        apb(1'b1, REG_SETTINGS, {29'h0, v});
        rd(REG_SETTINGS, {30'h0, v});
        repeat (4) begin
            {home_raw, limit_raw, gp_req, step_pulse, step_dir} <= 7'($random(seed));
            repeat (2) @(posedge pclk);
            check("io", {28'h0, home_raw ^ v[1], limit_raw ^ {2{v[0]}}, v[2] ? {step_dir,
                step_pulse} : gp_req}, {28'h0, home_active, limit_active, gp_out});
        end
        tx($sformatf("pp%0d\r\np 5\r\n", v));
        ln(0, "p");
        ln(0, "p 5");
        tx("");
        rd(REG_SETTINGS, 33'h5);
        tx("P\r\n0000 M5\r\n0003 \r\n0003 M\r\n0003 O4\r\n0008 ");
        ln(0, "P");
        ln(0, "M5");
        ln(0, "#M\010O4");
        tx("");
        rd(REG_STATUS, 33'h0_0008_0001);
        tx("P\r\n");
        ln(0, "P");
        memrd(10'h0, 32'h004D_0005);
        memrd(10'h3, 32'h004F_0004);
        tx("P200\r\n0200 M1\r\n0203 ");
        ln(0, "P200");
        ln(0, "M1");
        memrd(10'hC8, 32'h004B_00C8);
        tx("\r\nG300\r\n");
        pei_host_inst.put(CH_ESC);
        ln(0, "G300");
        repeat (6) @(posedge pclk);
        check("exec", {16'h0, 1'b1, 16'h012C}, {16'h0, ex});
        apb(1'b1, REG_CTRL, 32'h0000_4101);
        pei_host_inst.put(CH_CR);
        tx("AP\r\nAM\r\nAOM\r\nAAP\r\n");
        ln(1, "P");
        ln(1, "M7");
        ln(1, "#O\010M9");
        ln(1, "#");
        ln(1, "P");
        memrd(10'h0, 32'h004D_0007);
        memrd(10'h3, 32'h004D_0009);
        tx("");
        finish_test;
    end
endmodule
`default_nettype wire
